//--- ssfe_pkg.sv
// Purpose: Shared constants and types for the synchronous serial frame engine.
// Assumes: Master role, frames of 4 to 16 bits, system clock at 50 MHz.
// Notes: Size codes hold the frame length minus one.
package ssfe_pkg;

    localparam int unsigned DATA_W = 16;
    localparam int unsigned SIZE_W = 4;
    localparam int unsigned HALF_W = 16;
    localparam int unsigned TXQ_DEPTH = 8;
    localparam int unsigned RXB_DEPTH = 2;

    // Smallest size code, a 4-bit frame.
    localparam logic [3:0] MIN_SIZE_CODE = 4'h3;
    localparam logic [3:0] MAX_SIZE_CODE = 4'hf;

    // Transmit request is raised at or below this fill level.
    localparam int unsigned TXQ_IRQ_LEVEL = 4;

    // Phase lengths counted in half serial clock periods.
    localparam logic [1:0] SPI_LEAD_HALVES = 2'h1;
    localparam logic [1:0] SSI_LEAD_HALVES = 2'h2;
    localparam logic [1:0] GAP_HALVES = 2'h2;
    localparam logic [1:0] TAIL_PH0_HALVES = 2'h1;
    localparam logic [1:0] TAIL_PH1_HALVES = 2'h2;

    // Prescaler half value used when the programmed value is below 2.
    localparam logic [6:0] PRESCALE_HALF_MIN = 7'h01;

    // Format selection values.
    localparam logic FMT_PULSE = 1'b0;
    localparam logic FMT_SELECT = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LEAD,
        ST_BITS,
        ST_TAIL,
        ST_GAP
    } ssfe_state_t;

endpackage : ssfe_pkg

//--- ssfe_buf.sv
// Purpose: Small shift-style queue with valid and ready on both sides.
// Assumes: One clock; the head entry always sits in slot zero.
// Notes: All outputs come from flip-flops; the clock enable freezes it.
`timescale 1ns/1ns
`default_nettype none

module ssfe_buf #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 2,
    parameter int unsigned CW = $clog2(DEPTH + 1)
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [CW-1:0] count_o
);
    import ssfe_pkg::*;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [CW-1:0] cnt;
        logic in_rdy;
        logic out_vld;
    } ssfe_buf_state_t;

    ssfe_buf_state_t state_reg;
    ssfe_buf_state_t state_next;
    logic push;
    logic pop;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        push = in_valid_i && state_reg.in_rdy;
        pop = out_ready_i && state_reg.out_vld;
        state_next = state_reg;
        if (pop)
        begin
            for (int i = 0; i < int'(DEPTH) - 1; i++)
            begin
                state_next.mem[i] = state_reg.mem[i+1];
            end
        end
        // A word pushed during a pop lands one slot lower.
        if (push)
        begin
            state_next.mem[state_reg.cnt - CW'(pop)] = in_data_i;
        end
        state_next.cnt = state_reg.cnt + CW'(push) - CW'(pop);
        state_next.in_rdy = (state_next.cnt != CW'(DEPTH));
        state_next.out_vld = (state_next.cnt != '0);
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_reg <= '0;
            state_reg.in_rdy <= 1'b1;
        end
        else if (en_i)
        begin
            state_reg <= state_next;
        end
    end

    assign in_ready_o = state_reg.in_rdy;
    assign out_valid_o = state_reg.out_vld;
    assign out_data_o = state_reg.mem[0];
    assign count_o = state_reg.cnt;

endmodule : ssfe_buf

`default_nettype wire

//--- ssfe_engine.sv
// Purpose: Master framing engine for the pulse-framed and slave-select serial formats.
// Assumes: Inputs synchronous to clk_i; configuration changes only while disabled.
// Notes: A transmit queue feeds the shifter; a two-entry buffer holds received words.
`timescale 1ns/1ns
`default_nettype none

module ssfe_engine #(
    parameter int unsigned TXQ_DEPTH = ssfe_pkg::TXQ_DEPTH
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic clk_en_i,
    input wire logic port_operation_enable_i,
    input wire logic format_select_i,
    input wire logic clock_idle_polarity_i,
    input wire logic capture_edge_phase_i,
    input wire logic [ssfe_pkg::SIZE_W-1:0] data_size_i,
    input wire logic [7:0] clock_prescale_setting_i,
    input wire logic [7:0] clock_rate_divider_i,
    input wire logic [ssfe_pkg::DATA_W-1:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    output logic [ssfe_pkg::DATA_W-1:0] rx_data_o,
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    output logic tx_irq_o,
    output logic busy_o,
    output logic serial_clock_pin_o,
    output logic frame_select_pin_o,
    output logic serial_data_out_pin_o,
    output logic serial_data_out_pin_oe_o,
    input wire logic serial_data_in_pin_i
);
    import ssfe_pkg::*;

    localparam int unsigned TXQ_CW = $clog2(TXQ_DEPTH + 1);
    localparam int unsigned RXB_CW = $clog2(RXB_DEPTH + 1);

    typedef struct packed {
        ssfe_state_t st;
        logic [HALF_W-1:0] cnt;
        logic [4:0] k;
        logic [1:0] hc;
        logic fmt;
        logic clock_idle_polarity;
        logic ph;
        logic [SIZE_W-1:0] size;
        logic [HALF_W-1:0] half;
        logic [DATA_W-1:0] tx_sh;
        logic [DATA_W-1:0] rx_sh;
        logic [DATA_W-1:0] rx_word;
        logic rx_push;
        logic sclk;
        logic fss;
        logic sdo;
        logic sdo_oe;
        logic tx_irq;
        logic busy;
    } ssfe_core_t;

    ////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops.
    logic [1:0] rst_sync_reg;
    logic rst_n;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rst_sync_reg <= 2'h0;
        end
        else
        begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_reg[1];

    ////////////////////////////////////////////////////////////////////////
    // Transmit queue and receive buffer.
    logic [DATA_W-1:0] txq_data;
    logic txq_valid;
    logic txq_pop;
    logic [TXQ_CW-1:0] txq_count;
    logic rxb_ready;
    logic [RXB_CW-1:0] rxb_count;

    ssfe_buf #(
        .WIDTH(DATA_W),
        .DEPTH(TXQ_DEPTH),
        .CW(TXQ_CW)
    ) u_txq (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .en_i(clk_en_i),
        .in_data_i(tx_data_i),
        .in_valid_i(tx_valid_i),
        .in_ready_o(tx_ready_o),
        .out_data_o(txq_data),
        .out_valid_o(txq_valid),
        .out_ready_i(txq_pop),
        .count_o(txq_count)
    );

    ssfe_core_t r;
    ssfe_core_t s;

    ssfe_buf #(
        .WIDTH(DATA_W),
        .DEPTH(RXB_DEPTH)
    ) u_rxb (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .en_i(clk_en_i),
        .in_data_i(r.rx_word),
        .in_valid_i(r.rx_push),
        .in_ready_o(rxb_ready),
        .out_data_o(rx_data_o),
        .out_valid_o(rx_valid_o),
        .out_ready_i(rx_ready_i),
        .count_o(rxb_count)
    );

    ////////////////////////////////////////////////////////////////////////
    // Live configuration and serial clock timing.
    logic [SIZE_W-1:0] size_c;
    logic [6:0] pre_half;
    logic [HALF_W-1:0] half_len;
    logic tick;
    logic start_ok;
    logic rx_room;
    logic cont_ok;
    logic [4:0] last_k;
    logic do_load;
    logic [4:0] k_new;
    logic spi_ph1;
    logic [1:0] lead_len;
    logic [1:0] tail_len;

    assign size_c = (data_size_i < MIN_SIZE_CODE) ? MIN_SIZE_CODE : data_size_i;
    assign pre_half = (clock_prescale_setting_i[7:1] == 7'h00) ? PRESCALE_HALF_MIN
                                                               : clock_prescale_setting_i[7:1];
    assign half_len = HALF_W'(HALF_W'(pre_half) * (HALF_W'(clock_rate_divider_i) + 16'h0001));
    assign tick = (r.cnt == r.half - 16'h0001);
    // start on queued word
    // Counting the word still on its way keeps a stalled reader from losing one.
    assign rx_room = r.rx_push ? (rxb_count < RXB_CW'(RXB_DEPTH - 1)) : rxb_ready;
    assign start_ok = port_operation_enable_i && txq_valid && rx_room;
    // A word that follows at once needs room for the one still finishing.
    assign cont_ok = start_ok && (rxb_count < RXB_CW'(RXB_DEPTH - 1));
    assign last_k = {r.size, 1'b1};
    assign spi_ph1 = (r.fmt == FMT_SELECT) && r.ph;
    assign lead_len = (r.fmt == FMT_SELECT) ? SPI_LEAD_HALVES : SSI_LEAD_HALVES;
    assign tail_len = r.ph ? TAIL_PH1_HALVES : TAIL_PH0_HALVES;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        s = r;
        s.rx_push = 1'b0;
        txq_pop = 1'b0;
        do_load = 1'b0;
        k_new = r.k + 5'h01;
        if (r.st != ST_IDLE)
        begin
            s.cnt = tick ? '0 : r.cnt + 16'h0001;
        end
        case (r.st)
            ST_IDLE:
            begin
                s.cnt = '0;
                s.fmt = format_select_i;
                s.clock_idle_polarity = clock_idle_polarity_i;
                s.ph = capture_edge_phase_i;
                s.size = size_c;
                s.half = half_len;
                if (start_ok)
                begin
                    do_load = 1'b1;
                    s.st = ST_LEAD;
                end
            end
            ST_LEAD:
            begin
                if (tick)
                begin
                    s.hc = r.hc + 2'h1;
                    if (r.hc == lead_len - 2'h1)
                    begin
                        s.st = ST_BITS;
                        s.k = 5'h00;
                        if (!spi_ph1)
                        begin
                            s.sdo = r.tx_sh[DATA_W-1];
                            s.tx_sh = r.tx_sh << 1;
                        end
                    end
                end
            end
            ST_BITS:
            begin
                if (tick)
                begin
                    if (r.k == last_k)
                    begin
                        // phase 1 captures on second edge
                        if (spi_ph1)
                        begin
                            s.rx_sh = {r.rx_sh[DATA_W-2:0], serial_data_in_pin_i};
                        end
                        s.rx_push = 1'b1;
                        s.rx_word = s.rx_sh;
                        s.hc = 2'h0;
                        if (r.fmt == FMT_PULSE)
                        begin
                            s.st = cont_ok ? ST_LEAD : ST_IDLE;
                            do_load = cont_ok;
                        end
                        else if (r.ph && cont_ok)
                        begin
                            do_load = 1'b1;
                            s.st = ST_BITS;
                        end
                        else
                        begin
                            s.st = ST_TAIL;
                        end
                    end
                    else
                    begin
                        s.k = k_new;
                        // out on even k, in on odd k; spi_ph1 swaps them
                        if (k_new[0] == spi_ph1)
                        begin
                            s.sdo = r.tx_sh[DATA_W-1];
                            s.tx_sh = r.tx_sh << 1;
                        end
                        else
                        begin
                            s.rx_sh = {r.rx_sh[DATA_W-2:0], serial_data_in_pin_i};
                        end
                    end
                end
            end
            ST_TAIL:
            begin
                // select high after the tail, one half period or two for phase 1
                if (tick)
                begin
                    s.hc = r.hc + 2'h1;
                    if (r.hc == tail_len - 2'h1)
                    begin
                        s.hc = 2'h0;
                        s.st = (!r.ph && start_ok) ? ST_GAP : ST_IDLE;
                    end
                end
            end
            ST_GAP:
            begin
                if (tick)
                begin
                    s.hc = r.hc + 2'h1;
                    if (r.hc == GAP_HALVES - 2'h1)
                    begin
                        do_load = start_ok;
                        s.st = start_ok ? ST_LEAD : ST_IDLE;
                    end
                end
            end
            default:
            begin
                s.st = ST_IDLE;
            end
        endcase

        if (do_load)
        begin
            txq_pop = 1'b1;
            s.tx_sh = txq_data << (MAX_SIZE_CODE - s.size);
            s.rx_sh = '0;
            s.k = 5'h00;
            s.hc = 2'h0;
            s.cnt = '0;
        end
        if (!port_operation_enable_i && r.st != ST_IDLE)
        begin
            s.st = ST_IDLE;
            txq_pop = 1'b0;
            s.rx_push = 1'b0;
        end

        // clock runs only in a frame
        case (s.st)
            ST_IDLE:
            begin
                s.sclk = (s.fmt == FMT_SELECT) ? s.clock_idle_polarity : 1'b0;
                s.fss = (s.fmt == FMT_SELECT);
                s.sdo = 1'b0;
            end
            ST_LEAD:
            begin
                s.sclk = (s.fmt == FMT_PULSE) ? (s.hc == 2'h0) : s.clock_idle_polarity;
                s.fss = (s.fmt == FMT_PULSE);
            end
            ST_BITS:
            begin
                s.sclk = (s.fmt == FMT_SELECT) ? (s.clock_idle_polarity ^ s.k[0]) : !s.k[0];
                s.fss = 1'b0;
            end
            ST_TAIL:
            begin
                s.sclk = s.clock_idle_polarity;
                s.fss = 1'b0;
            end
            ST_GAP:
            begin
                s.sclk = s.clock_idle_polarity;
                s.fss = 1'b1;
            end
            default:
            begin
                s.sclk = 1'b0;
                s.fss = 1'b0;
            end
        endcase
        s.sdo_oe = port_operation_enable_i && !(s.fmt == FMT_PULSE && s.st == ST_IDLE);
        s.tx_irq = (txq_count <= TXQ_CW'(TXQ_IRQ_LEVEL)) || !port_operation_enable_i;
        s.busy = (s.st != ST_IDLE);
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= '0;
            r.st <= ST_IDLE;
            r.fss <= 1'b0;
            r.tx_irq <= 1'b1;
        end
        else if (clk_en_i)
        begin
            r <= s;
        end
    end

    assign tx_irq_o = r.tx_irq;
    assign busy_o = r.busy;
    assign serial_clock_pin_o = r.sclk;
    assign frame_select_pin_o = r.fss;
    assign serial_data_out_pin_o = r.sdo;
    assign serial_data_out_pin_oe_o = r.sdo_oe;

    ////////////////////////////////////////////////////////////////////////
    // Checks on the engine behaviour.
    property p_tx_irq;
        @(posedge clk_i) disable iff (!rst_n)
        clk_en_i |=> tx_irq_o == (($past(txq_count) <= TXQ_CW'(TXQ_IRQ_LEVEL)) || !$past(port_operation_enable_i));
    endproperty
    a_tx_irq: assert property (p_tx_irq) else $error("transmit request level wrong");

    property p_start;
        @(posedge clk_i) disable iff (!rst_n)
        (clk_en_i && r.st == ST_IDLE && start_ok) |=> (r.st == ST_LEAD && busy_o);
    endproperty
    a_start: assert property (p_start) else $error("frame did not start");

    property p_ssi_idle;
        @(posedge clk_i) disable iff (!rst_n)
        (r.st == ST_IDLE && r.fmt == FMT_PULSE) |-> (!serial_clock_pin_o && !frame_select_pin_o && !serial_data_out_pin_oe_o);
    endproperty
    a_ssi_idle: assert property (p_ssi_idle) else $error("pulse-framed idle pins wrong");

    property p_spi_idle;
        @(posedge clk_i) disable iff (!rst_n)
        (r.st == ST_IDLE && r.fmt == FMT_SELECT) |-> (frame_select_pin_o && !serial_data_out_pin_o && serial_clock_pin_o == r.clock_idle_polarity);
    endproperty
    a_spi_idle: assert property (p_spi_idle) else $error("slave-select idle pins wrong");

    property p_fss_low;
        @(posedge clk_i) disable iff (!rst_n)
        (r.fmt == FMT_SELECT && (r.st == ST_LEAD || r.st == ST_BITS || r.st == ST_TAIL)) |-> !frame_select_pin_o;
    endproperty
    a_fss_low: assert property (p_fss_low) else $error("select not low during frame");

    property p_ssi_pulse;
        @(posedge clk_i) disable iff (!rst_n)
        (r.fmt == FMT_PULSE && r.st != ST_IDLE) |-> (frame_select_pin_o == (r.st == ST_LEAD));
    endproperty
    a_ssi_pulse: assert property (p_ssi_pulse) else $error("pulse-framed select wrong");

    property p_tail_end;
        @(posedge clk_i) disable iff (!rst_n)
        (clk_en_i && port_operation_enable_i && r.st == ST_TAIL && tick && r.hc == tail_len - 2'h1)
            |=> frame_select_pin_o;
    endproperty
    a_tail_end: assert property (p_tail_end) else $error("select not released after tail");

    property p_gap_pulse;
        @(posedge clk_i) disable iff (!rst_n)
        (r.st == ST_GAP) |-> (frame_select_pin_o && !r.ph);
    endproperty
    a_gap_pulse: assert property (p_gap_pulse) else $error("gap pulse wrong");

    property p_ph1_cont;
        @(posedge clk_i) disable iff (!rst_n)
        (clk_en_i && spi_ph1 && r.st == ST_BITS && tick && r.k == last_k && cont_ok)
            |=> (r.st == ST_BITS && !frame_select_pin_o && r.k == 5'h00);
    endproperty
    a_ph1_cont: assert property (p_ph1_cont) else $error("phase 1 run broke select");

    property p_sdo_off;
        @(posedge clk_i) disable iff (!rst_n)
        (clk_en_i && !port_operation_enable_i) |=> !serial_data_out_pin_oe_o;
    endproperty
    a_sdo_off: assert property (p_sdo_off) else $error("data driven while disabled");

    property p_rx_push;
        @(posedge clk_i) disable iff (!rst_n)
        (clk_en_i && port_operation_enable_i && r.st == ST_BITS && tick && r.k == last_k) |=> r.rx_push;
    endproperty
    a_rx_push: assert property (p_rx_push) else $error("received word not pushed");

    property p_rx_room;
        @(posedge clk_i) disable iff (!rst_n)
        r.rx_push |-> rxb_ready;
    endproperty
    a_rx_room: assert property (p_rx_room) else $error("received word met a full buffer");

endmodule : ssfe_engine

`default_nettype wire

//--- ssfe_slave.sv
// Purpose: Serial slave model facing the frame engine.
// Assumes: The master makes clock and select.
// Notes: A data line released by select shows its last bit inverted; pulse framing inverts it during the next frame pulse.
`timescale 1ns/1ns
`default_nettype none
module ssfe_slave (
    input wire logic fmt_i,
    input wire logic pol_i,
    input wire logic ph_i,
    input wire logic [4:0] nbits_i,
    input wire logic [15:0] word_i,
    input wire logic sclk_i,
    input wire logic fss_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic [15:0] got_o
);
    logic [4:0] idx = 5'h00, cnt = 5'h00;
    logic [15:0] sh = 16'h0000;
    logic run = 1'b0;
    initial miso_o = 1'b0;
    task automatic drive();
        miso_o = word_i[nbits_i - 5'h01 - idx];
        idx = (idx + 5'h01 == nbits_i) ? 5'h00 : idx + 5'h01;
    endtask : drive
    task automatic restart();
        {run, idx, cnt, sh} = {~fmt_i, 26'h0000000};
        miso_o = ~miso_o;
    endtask : restart
    always @(fss_i)
        if (fmt_i)
        begin
            restart();
            if (!fss_i && !ph_i)
                drive();
        end
    always @(sclk_i)
        if (!fmt_i && !sclk_i && fss_i)
            restart();
        else if (fmt_i ? !fss_i : run)
            if (fmt_i ? !(sclk_i ^ pol_i ^ ph_i) : sclk_i)
                drive();
            else
            begin
                sh = {sh[14:0], mosi_i};
                cnt = cnt + 5'h01;
                if (cnt == nbits_i)
                begin
                    got_o = sh;
                    {run, cnt, sh} = {fmt_i, 21'h000000};
                end
            end
endmodule : ssfe_slave
`default_nettype wire

//--- ssfe_engine_bench.sv
// Purpose: Self-checking bench for the serial frame engine.
// Assumes: Prescale 2 and divider 1, so a half bit is two clocks.
// Notes: Each format sends a six-word burst to the slave model.
`timescale 1ns/1ns
`default_nettype none
module ssfe_engine_bench;
    import ssfe_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, en = 1'b0, txv = 1'b0, rxr = 1'b0;
    logic fmt = FMT_SELECT, pol = 1'b0, ph = 1'b0;
    logic [3:0] size = MAX_SIZE_CODE;
    logic [15:0] sw = 16'h0000, tw = 16'h0000, rxd, got;
    logic txr, rxv, irq, busy, sclk, fss, sdo, oe, sdi;
    int fail_count = 0, check_count = 0, rises = 0;
    time rise_t = 0, bit_t = 0;
    initial forever #10 clk = ~clk;
    always @(posedge fss)
        rises++;
    always @(posedge sclk)
    begin
        bit_t = $time - rise_t;
        rise_t = $time;
    end
    ssfe_engine i_ssfe_engine (
        .clk_i(clk), .arst_n_i(arst_n), .clk_en_i(1'b1), .port_operation_enable_i(en),
        .format_select_i(fmt), .clock_idle_polarity_i(pol), .capture_edge_phase_i(ph), .data_size_i(size),
        .clock_prescale_setting_i(8'h02), .clock_rate_divider_i(8'h01), .tx_data_i(tw), .tx_valid_i(txv),
        .tx_ready_o(txr), .rx_data_o(rxd), .rx_valid_o(rxv), .rx_ready_i(rxr), .tx_irq_o(irq), .busy_o(busy),
        .serial_clock_pin_o(sclk), .frame_select_pin_o(fss), .serial_data_out_pin_o(sdo),
        .serial_data_out_pin_oe_o(oe), .serial_data_in_pin_i(sdi)
    );
    ssfe_slave i_ssfe_slave (
        .fmt_i(fmt), .pol_i(pol), .ph_i(ph), .nbits_i({1'b0, size} + 5'h01), .word_i(sw),
        .sclk_i(sclk), .fss_i(fss), .mosi_i(sdo), .miso_o(sdi), .got_o(got)
    );
    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e)
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        fail_count += (g !== e);
    endtask : cmp
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    initial
    begin
        repeat (8) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        cmp({14'h0000, irq, oe}, 16'h0002);
        for (int k = 0; k < 5; k++)
        begin
            fmt = (k < 4) ? FMT_SELECT : FMT_PULSE;
            {pol, ph} = 2'(k);
            size = (k == 4) ? MIN_SIZE_CODE : ((k == 1 || k == 2) ? 4'h7 : MAX_SIZE_CODE);
            sw = 16'h63b1 & (16'hffff >> (4'hf - size));
            tw = 16'h9a5c & (16'hffff >> (4'hf - size));
            repeat (6)
            begin
                @(negedge clk);
                while (txr !== 1'b1)
                    @(negedge clk);
                txv = 1'b1;
                @(negedge clk);
                txv = 1'b0;
            end
            rises = 0;
            en = 1'b1;
            repeat (2) @(negedge clk);
            cmp({15'h0000, irq}, 16'h0000);
            repeat (ph ? 1 : 300) @(negedge clk);
            repeat (6)
            begin
                while (rxv !== 1'b1)
                    @(negedge clk);
                cmp(rxd, sw);
                rxr = 1'b1;
                @(negedge clk);
                rxr = 1'b0;
                @(negedge clk);
            end
            while (busy !== 1'b0)
                @(negedge clk);
            repeat (4) @(negedge clk);
            cmp(got, tw);
            cmp(16'(rises), (fmt && ph) ? 16'h0001 : 16'h0006);
            cmp({11'h000, irq, sclk, fss, oe, sdo & oe}, {12'h001, fmt ? {pol, 3'h6} : 4'h0});
            cmp(16'(bit_t), 16'h0050);
            en = 1'b0;
            repeat (2) @(negedge clk);
            cmp({15'h0000, oe}, 16'h0000);
        end
        give_verdict();
    end
    initial
    begin
        repeat (40000) @(posedge clk);
        fail_count++;
        give_verdict();
    end
endmodule : ssfe_engine_bench
`default_nettype wire
